/* logic/sync_serial_consts.svh */
// Offsets, field positions, reset values and timing counts of the serial port registers
`ifndef SYNC_SERIAL_CONSTS_SVH
`define SYNC_SERIAL_CONSTS_SVH

// Register byte offsets
`define OFS_FRAME_COUNT      8'h04
`define OFS_GLOBAL_ENABLE    8'h08
`define OFS_WIRE_CONTROL     8'h0c
`define OFS_TARGET_SELECT    8'h10
`define OFS_CLOCK_DIVIDER    8'h14
`define OFS_TX_THRESHOLD     8'h18
`define OFS_RX_THRESHOLD     8'h1c
`define OFS_TX_FILL_LEVEL    8'h20
`define OFS_RX_FILL_LEVEL    8'h24
`define OFS_PORT_STATUS      8'h28
`define OFS_IRQ_MASK         8'h2c
`define OFS_IRQ_MASKED       8'h30
`define OFS_IRQ_RAW          8'h34
`define OFS_TX_OVF_CLEAR     8'h38
`define OFS_RX_OVF_CLEAR     8'h3c
`define OFS_RX_UNF_CLEAR     8'h40
`define OFS_CONTENTION_CLEAR 8'h44
`define OFS_ALL_IRQ_CLEAR    8'h48
`define OFS_DMA_ENABLE       8'h4c
`define OFS_IRQ_WRITE_CLEAR  8'h80

// Interrupt source bit positions
`define IRQ_TX_EMPTY   0
`define IRQ_TX_OVF     1
`define IRQ_RX_UNF     2
`define IRQ_RX_OVF     3
`define IRQ_RX_FULL    4
`define IRQ_CONTENTION 5

// Status bit positions
`define ST_BUSY        0
`define ST_TX_NOT_FULL 1
`define ST_TX_EMPTY    2
`define ST_RX_NOT_EMPTY 3
`define ST_RX_FULL     4
`define ST_TX_ERROR    5
`define ST_COLLISION   6

// Reset values
`define RST_ZERO16     16'h0000
`define RST_ZERO8      8'h00
`define RST_ZERO6      6'h00

// FIFO depth and frame length
`define FIFO_DEPTH     8'h10
`define FRAME_EDGES    5'h10

`endif

/* logic/sync_serial_pkg.sv */
// Types shared by the serial port register block
package sync_serial_pkg;
    typedef enum logic [0:0] {ENG_IDLE, ENG_SHIFT} engine_state_t;
    typedef logic [5:0] irq_vec_t;
endpackage

/* logic/sync_serial_sync.sv */
// Two flip-flop synchroniser for one asynchronous pin
`timescale 1ns/1ps
`default_nettype none
module sync_serial_sync
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic d,
    output var  logic q
);
    logic first;

    // First stage feeds only the second stage; resets to the idle-high level
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            first <= 1'b1;
            q     <= 1'b1;
        end
        else
        begin
            first <= d;
            q     <= first;
        end
    end
endmodule
`default_nettype wire

/* logic/sync_serial_clock_divider.sv */
// Half-period tick generator for the serial clock
`timescale 1ns/1ps
`default_nettype none
module sync_serial_clock_divider
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic [15:0] divisor,
    output var  logic        tick
);
    logic [14:0] count;
    logic [14:0] half;

    // Odd divisors round down; the bottom bit is ignored
    assign half = (divisor[15:1] == 15'h0000) ? 15'h0001 : divisor[15:1];

    // Count restarts whenever the engine stops so every frame begins in phase
    always_ff @(posedge clock)
    begin
        if (rst || !run)
        begin
            count <= 15'h0000;
            tick  <= 1'b0;
        end
        else if (count == half - 15'h0001)
        begin
            count <= 15'h0000;
            tick  <= 1'b1;
        end
        else
        begin
            count <= count + 15'h0001;
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* logic/sync_serial_control_registers.sv */
// Register bank, interrupt logic and frame sequencer of the serial port master
//
// Our own choice: strobed register access.
`include "sync_serial_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sync_serial_control_registers
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output var  logic [31:0] rdata,
    input  wire logic [7:0]  tx_entries,
    input  wire logic [7:0]  rx_entries,
    input  wire logic        tx_overflow_evt,
    input  wire logic        rx_overflow_evt,
    input  wire logic        rx_underflow_evt,
    input  wire logic        tx_underrun_evt,
    input  wire logic        contention_in_n,
    output var  logic        irq,
    output var  logic        sclk,
    output var  logic        select_n,
    output var  logic        tx_pop,
    output var  logic        rx_push,
    output var  logic        tx_dma_req,
    output var  logic        rx_dma_req
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [15:0] frame_total;
    logic        port_on;
    logic        wire_handshake;
    logic        wire_direction;
    logic        wire_transfer_kind;
    logic        target_select;
    logic [15:0] clock_divisor;
    logic [7:0]  tx_threshold_value;
    logic [7:0]  rx_threshold_value;
    logic [5:0]  irq_mask;
    logic        tx_dma_on;
    logic        rx_dma_on;
    logic        tx_ovf_sticky;
    logic        rx_ovf_sticky;
    logic        rx_unf_sticky;
    logic        contention_raw;
    logic        transmission_error;
    logic        collision_error;
    logic        contention_sync;
    logic        tick;
    logic        busy;
    logic        frames_finished;
    logic [15:0] frames_done;
    logic [4:0]  edge_count;
    sync_serial_pkg::engine_state_t state;
    sync_serial_pkg::irq_vec_t      irq_raw;
    sync_serial_pkg::irq_vec_t      irq_pending;
    logic [6:0]  port_status;
    logic [31:0] next_rdata;
    logic        cfg_wr;
    logic        rd_txo;
    logic        rd_rxo;
    logic        rd_rxu;
    logic        rd_mst;
    logic        rd_all;
    logic        wr_clr;

    // Configuration is frozen while the port runs so a frame never sees a half-written setup
    assign cfg_wr = wr && !port_on;
    assign rd_txo = rd && (addr == `OFS_TX_OVF_CLEAR);
    assign rd_rxo = rd && (addr == `OFS_RX_OVF_CLEAR);
    assign rd_rxu = rd && (addr == `OFS_RX_UNF_CLEAR);
    assign rd_mst = rd && (addr == `OFS_CONTENTION_CLEAR);
    assign rd_all = rd && (addr == `OFS_ALL_IRQ_CLEAR);
    assign wr_clr = wr && (addr == `OFS_IRQ_WRITE_CLEAR);

    // ------------------------------------------------------------
    // Pin synchroniser and divider
    // ------------------------------------------------------------
    sync_serial_sync u_contention_sync
    (
        .clock (clock),
        .rst   (rst),
        .d     (contention_in_n),
        .q     (contention_sync)
    );

    sync_serial_clock_divider u_divider
    (
        .clock   (clock),
        .rst     (rst),
        .run     (busy),
        .divisor (clock_divisor),
        .tick    (tick)
    );

    // ------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------
    // Setup registers, accepted only while the port is off
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            frame_total        <= `RST_ZERO16;
            wire_handshake     <= 1'b0;
            wire_direction     <= 1'b0;
            wire_transfer_kind <= 1'b0;
            target_select      <= 1'b0;
            clock_divisor      <= `RST_ZERO16;
            tx_threshold_value <= `RST_ZERO8;
            rx_threshold_value <= `RST_ZERO8;
        end
        else if (cfg_wr)
        begin
            case (addr)
                `OFS_FRAME_COUNT:   frame_total <= wdata[15:0];
                `OFS_WIRE_CONTROL:
                begin
                    wire_handshake     <= wdata[2];
                    wire_direction     <= wdata[1];
                    wire_transfer_kind <= wdata[0];
                end
                `OFS_TARGET_SELECT: target_select <= wdata[0];
                `OFS_CLOCK_DIVIDER: clock_divisor <= wdata[15:0];
                `OFS_TX_THRESHOLD:  tx_threshold_value <= wdata[7:0];
                `OFS_RX_THRESHOLD:  rx_threshold_value <= wdata[7:0];
                default:            frame_total <= frame_total;
            endcase
        end
    end

    // Enable, mask and DMA enables stay writable at any time
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            port_on   <= 1'b0;
            irq_mask  <= `RST_ZERO6;
            tx_dma_on <= 1'b0;
            rx_dma_on <= 1'b0;
        end
        else if (wr)
        begin
            if (addr == `OFS_GLOBAL_ENABLE)
                port_on <= wdata[0];
            if (addr == `OFS_IRQ_MASK)
                irq_mask <= wdata[5:0];
            if (addr == `OFS_DMA_ENABLE)
            begin
                tx_dma_on <= wdata[1];
                rx_dma_on <= wdata[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Sticky interrupt sources
    // ------------------------------------------------------------
    // A new event in the clearing cycle survives: set wins over clear
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            tx_ovf_sticky  <= 1'b0;
            rx_ovf_sticky  <= 1'b0;
            rx_unf_sticky  <= 1'b0;
            contention_raw <= 1'b0;
        end
        else
        begin
            tx_ovf_sticky  <= tx_overflow_evt
                || (tx_ovf_sticky && !(rd_txo || rd_all || (wr_clr && wdata[`IRQ_TX_OVF])));
            rx_ovf_sticky  <= rx_overflow_evt
                || (rx_ovf_sticky && !(rd_rxo || rd_all || (wr_clr && wdata[`IRQ_RX_OVF])));
            rx_unf_sticky  <= rx_underflow_evt
                || (rx_unf_sticky && !(rd_rxu || rd_all || (wr_clr && wdata[`IRQ_RX_UNF])));
            contention_raw <= (port_on && !contention_sync)
                || (contention_raw && !(rd_mst || rd_all
                || (wr_clr && wdata[`IRQ_CONTENTION])));
        end
    end

    // Error flags of the status register, cleared by reading it
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            transmission_error <= 1'b0;
            collision_error    <= 1'b0;
        end
        else
        begin
            transmission_error <= tx_underrun_evt
                || (transmission_error && !(rd && addr == `OFS_PORT_STATUS));
            collision_error    <= (port_on && !contention_sync)
                || (collision_error && !(rd && addr == `OFS_PORT_STATUS));
        end
    end

    // Threshold levels are live, not sticky; they follow the FIFO fill
    always_comb
    begin
        irq_raw                  = 6'h00;
        irq_raw[`IRQ_TX_EMPTY]   = tx_entries <= tx_threshold_value;
        irq_raw[`IRQ_TX_OVF]     = tx_ovf_sticky;
        irq_raw[`IRQ_RX_UNF]     = rx_unf_sticky;
        irq_raw[`IRQ_RX_OVF]     = rx_ovf_sticky;
        irq_raw[`IRQ_RX_FULL]    = rx_entries > rx_threshold_value;
        irq_raw[`IRQ_CONTENTION] = contention_raw;
    end

    assign irq_pending = irq_raw & irq_mask;

    // Interrupt level and DMA requests leave through flip-flops
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            irq        <= 1'b0;
            tx_dma_req <= 1'b0;
            rx_dma_req <= 1'b0;
        end
        else
        begin
            irq        <= |irq_pending;
            tx_dma_req <= tx_dma_on && irq_raw[`IRQ_TX_EMPTY];
            rx_dma_req <= rx_dma_on && irq_raw[`IRQ_RX_FULL];
        end
    end

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    assign busy = (state == sync_serial_pkg::ENG_SHIFT);

    // Runs frame_total+1 frames, then waits for the port to be switched off
    always_ff @(posedge clock)
    begin
        if (rst || !port_on)
        begin
            state           <= sync_serial_pkg::ENG_IDLE;
            sclk            <= 1'b0;
            select_n        <= 1'b1;
            tx_pop          <= 1'b0;
            rx_push         <= 1'b0;
            edge_count      <= 5'h00;
            frames_done     <= `RST_ZERO16;
            frames_finished <= 1'b0;
        end
        else
        begin
            tx_pop  <= 1'b0;
            rx_push <= 1'b0;
            case (state)
                sync_serial_pkg::ENG_IDLE:
                begin
                    select_n <= 1'b1;
                    if (target_select && !frames_finished && tx_entries != `RST_ZERO8)
                    begin
                        state      <= sync_serial_pkg::ENG_SHIFT;
                        select_n   <= 1'b0;
                        tx_pop     <= 1'b1;
                        edge_count <= 5'h00;
                    end
                end
                sync_serial_pkg::ENG_SHIFT:
                begin
                    if (tick)
                    begin
                        sclk       <= !sclk;
                        edge_count <= edge_count + 5'h01;
                        if (edge_count == `FRAME_EDGES - 5'h01)
                        begin
                            state       <= sync_serial_pkg::ENG_IDLE;
                            select_n    <= 1'b1; // Idle gap so the target sees each frame
                            rx_push     <= 1'b1;
                            frames_done <= frames_done + 16'h0001;
                            if (frames_done == frame_total)
                                frames_finished <= 1'b1;
                        end
                    end
                end
                default: state <= sync_serial_pkg::ENG_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb
    begin
        port_status                   = 7'h00;
        port_status[`ST_BUSY]         = busy;
        port_status[`ST_TX_NOT_FULL]  = tx_entries != `FIFO_DEPTH;
        port_status[`ST_TX_EMPTY]     = tx_entries == `RST_ZERO8;
        port_status[`ST_RX_NOT_EMPTY] = rx_entries != `RST_ZERO8;
        port_status[`ST_RX_FULL]      = rx_entries == `FIFO_DEPTH;
        port_status[`ST_TX_ERROR]     = transmission_error;
        port_status[`ST_COLLISION]    = collision_error;
    end

    // Clear registers report the state before the clear takes hold
    always_comb
    begin
        next_rdata = 32'h00000000;
        case (addr)
            `OFS_FRAME_COUNT:      next_rdata[15:0] = frame_total;
            `OFS_GLOBAL_ENABLE:    next_rdata[0]    = port_on;
            `OFS_WIRE_CONTROL:     next_rdata[2:0]  = {wire_handshake, wire_direction,
                                                       wire_transfer_kind};
            `OFS_TARGET_SELECT:    next_rdata[0]    = target_select;
            `OFS_CLOCK_DIVIDER:    next_rdata[15:0] = clock_divisor;
            `OFS_TX_THRESHOLD:     next_rdata[7:0]  = tx_threshold_value;
            `OFS_RX_THRESHOLD:     next_rdata[7:0]  = rx_threshold_value;
            `OFS_TX_FILL_LEVEL:    next_rdata[7:0]  = tx_entries;
            `OFS_RX_FILL_LEVEL:    next_rdata[7:0]  = rx_entries;
            `OFS_PORT_STATUS:      next_rdata[6:0]  = port_status;
            `OFS_IRQ_MASK:         next_rdata[5:0]  = irq_mask;
            `OFS_IRQ_MASKED:       next_rdata[5:0]  = irq_pending;
            `OFS_IRQ_RAW:          next_rdata[5:0]  = irq_raw;
            `OFS_TX_OVF_CLEAR:     next_rdata[0]    = tx_ovf_sticky;
            `OFS_RX_OVF_CLEAR:     next_rdata[0]    = rx_ovf_sticky;
            `OFS_RX_UNF_CLEAR:     next_rdata[0]    = rx_unf_sticky;
            `OFS_CONTENTION_CLEAR: next_rdata[0]    = contention_raw;
            `OFS_ALL_IRQ_CLEAR:    next_rdata[0]    = |irq_raw;
            `OFS_DMA_ENABLE:       next_rdata[1:0]  = {tx_dma_on, rx_dma_on};
            default:               next_rdata       = 32'h00000000;
        endcase
    end

    // Read data stand for one cycle only, zero otherwise
    always_ff @(posedge clock)
    begin
        if (rst || !rd)
            rdata <= 32'h00000000;
        else
            rdata <= next_rdata;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_txo_read_clear: assert property (rd_txo && tx_ovf_sticky && !tx_overflow_evt |=>
        rdata[0] && !tx_ovf_sticky) else $error("tx overflow clear-on-read failed");
    a_rxo_read_clear: assert property (rd_rxo && rx_ovf_sticky && !rx_overflow_evt |=>
        rdata[0] && !rx_ovf_sticky) else $error("rx overflow clear-on-read failed");
    a_rxu_read_clear: assert property (rd_rxu && rx_unf_sticky && !rx_underflow_evt |=>
        rdata[0] && !rx_unf_sticky) else $error("rx underflow clear-on-read failed");
    a_mst_read_clear: assert property (rd_mst && contention_sync |=>
        rdata[0] == $past(contention_raw) && !contention_raw) else $error("contention clear failed");
    a_all_read_clear: assert property (rd_all && !tx_overflow_evt && !rx_overflow_evt
        && !rx_underflow_evt && contention_sync |=> irq_raw[3:1] == 3'h0 && !contention_raw
        && rdata[0] == $past(|irq_raw)) else $error("combined clear failed");
    a_mask_reset_zero: assert property ($fell(rst) |-> irq_mask == 6'h00)
        else $error("mask not zero after reset");
    a_masked_read: assert property (rd && addr == `OFS_IRQ_MASKED |=>
        rdata == {26'h0, $past(irq_raw & irq_mask)}) else $error("masked status read wrong");
    a_raw_read: assert property (rd && addr == `OFS_IRQ_RAW |=>
        rdata == {26'h0, $past(irq_raw)}) else $error("raw status read wrong");
    a_status_read: assert property (rd && addr == `OFS_PORT_STATUS |=>
        rdata[2] == ($past(tx_entries) == 8'h00) && rdata[0] == $past(busy)
        && rdata[31:7] == 25'h0) else $error("status read wrong");
    a_tx_thresh_write: assert property (cfg_wr && addr == `OFS_TX_THRESHOLD |=>
        tx_threshold_value == $past(wdata[7:0])) else $error("tx threshold not written");
    a_rx_thresh_write: assert property (cfg_wr && addr == `OFS_RX_THRESHOLD |=>
        rx_threshold_value == $past(wdata[7:0])) else $error("rx threshold not written");
    a_frame_count_write: assert property (cfg_wr && addr == `OFS_FRAME_COUNT |=>
        frame_total == $past(wdata[15:0])) else $error("frame count not written");
    a_irq_follows: assert property (irq_pending != 6'h00 ##1 irq_pending != 6'h00 |->
        irq) else $error("irq not raised for pending source");
    a_irq_quiet: assert property (irq_mask == 6'h00 |=> !irq)
        else $error("irq raised while fully masked");
    a_disabled_idle: assert property (!port_on |=> !busy && select_n && !tx_pop)
        else $error("transfer while port disabled");
    a_config_frozen: assert property (wr && port_on |=> $stable(clock_divisor)
        && $stable(frame_total)) else $error("config changed while enabled");

    c_frame_start: cover property (tx_pop ##[1:200] rx_push);
    c_irq_raised: cover property ($rose(irq));
    c_clear_read: cover property (rd_all && |irq_raw);
    c_set_wins: cover property (rd_txo && tx_overflow_evt);
endmodule
`default_nettype wire

/* verification/serial_flash_model.sv */
// Behavioural serial memory seen across the port pins
`timescale 1ns/1ps
`default_nettype none
module serial_flash_model
(
    input  wire logic       sclk,
    input  wire logic       select_n,
    input  wire logic       contend,
    output var  logic       contention_in_n,
    output var  logic [7:0] frames,
    output var  logic [7:0] edges
);
    // A second master pulls the shared pin low while it contends
    assign contention_in_n = !contend;
    // Frames and clock edges are counted only while selected
    initial
    begin
        frames = 8'h00;
        edges  = 8'h00;
    end
    always @(negedge select_n) frames = frames + 8'h01;
    always @(posedge sclk) if (!select_n) edges = edges + 8'h01;
endmodule
`default_nettype wire

/* verification/sync_serial_control_registers_test.sv */
// Self-checking bench for the serial port register block
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_consts.svh"
module sync_serial_control_registers_test;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  tx_ent = 8'h00;
    logic [7:0]  rx_ent = 8'h00;
    logic [2:0]  evt = 3'h0;
    logic        contend = 1'b0;
    logic        underrun = 1'b0;
    logic [31:0] rdata;
    logic        contention_in_n;
    logic        irq;
    logic        sclk;
    logic        select_n;
    logic        tx_dma_req;
    logic        rx_dma_req;
    logic [7:0]  frames;
    logic [7:0]  edges;
    logic [5:0]  sticky = 6'h00;
    logic [5:0]  raw;
    logic [7:0]  tx_thr = 8'h00;
    logic [7:0]  rx_thr = 8'h00;
    logic [31:0] rnd;
    logic [31:0] seen;
    logic [7:0]  clr_ofs [3] = '{`OFS_TX_OVF_CLEAR, `OFS_RX_OVF_CLEAR, `OFS_RX_UNF_CLEAR};
    int          rbit [3] = '{1, 3, 2};
    int          errors = 0;
    int          check_count = 0;

    sync_serial_control_registers i_dut
    (
        .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .tx_entries(tx_ent), .rx_entries(rx_ent),
        .tx_overflow_evt(evt[0]), .rx_overflow_evt(evt[1]), .rx_underflow_evt(evt[2]),
        .tx_underrun_evt(underrun), .contention_in_n(contention_in_n), .irq(irq),
        .sclk(sclk), .select_n(select_n), .tx_pop(), .rx_push(),
        .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req)
    );
    serial_flash_model i_flash
    (
        .sclk(sclk), .select_n(select_n), .contend(contend),
        .contention_in_n(contention_in_n), .frames(frames), .edges(edges)
    );

    // ----------------------------------------
    // Expectations and bus tasks
    // ----------------------------------------
    // Sticky events plus the two threshold levels, which cannot be cleared
    function automatic logic [5:0] exp_raw();
        return {sticky[5], rx_ent > rx_thr, sticky[3:1], tx_ent <= tx_thr};
    endfunction
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    // Strobes drop at the edge and tasks return one step later so no signal is set twice at once
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        check(name, rdata, exp);
    endtask
    task automatic pulse(input logic [2:0] e);
        evt <= e;
        @(posedge clock);
        evt <= 3'h0;
        #1;
        sticky = sticky | {2'b00, e[1], e[2], e[0], 1'b0};
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog and test sequence
    // ----------------------------------------
    initial
    begin
        forever #2 clock = ~clock;
    end
    // The whole run needs well under 2000 cycles
    initial
    begin
        #20000;
        errors++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(32'h2c517fc6));
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        rd_chk("frame_count", `OFS_FRAME_COUNT, 32'h0);
        rd_chk("tx_threshold", `OFS_TX_THRESHOLD, 32'h0);
        rd_chk("rx_threshold", `OFS_RX_THRESHOLD, 32'h0);
        rd_chk("irq_mask", `OFS_IRQ_MASK, 32'h0);
        rd_chk("unmapped", 8'h5c, 32'h0);
        $display("test reset_values done");
        // Random configuration, levels and events; upper bits must read back zero
        for (int i = 0; i < 12; i++)
        begin
            rnd = $urandom();
            tx_thr = 8'($urandom_range(20));
            rx_thr = 8'($urandom_range(20));
            tx_ent <= 8'($urandom_range(16));
            rx_ent <= 8'($urandom_range(16));
            reg_write(`OFS_IRQ_MASK, rnd);
            reg_write(`OFS_FRAME_COUNT, rnd);
            reg_write(`OFS_TX_THRESHOLD, {rnd[31:8], tx_thr});
            reg_write(`OFS_RX_THRESHOLD, {rnd[31:8], rx_thr});
            reg_write(`OFS_DMA_ENABLE, rnd);
            pulse(rnd[9:7]);
            raw = exp_raw();
            rd_chk("frame_count", `OFS_FRAME_COUNT, {16'h0, rnd[15:0]});
            rd_chk("irq_mask", `OFS_IRQ_MASK, {26'h0, rnd[5:0]});
            rd_chk("tx_threshold", `OFS_TX_THRESHOLD, {24'h0, tx_thr});
            rd_chk("rx_threshold", `OFS_RX_THRESHOLD, {24'h0, rx_thr});
            rd_chk("raw_status", `OFS_IRQ_RAW, {26'h0, raw});
            rd_chk("masked_status", `OFS_IRQ_MASKED, {26'h0, raw & rnd[5:0]});
            rd_chk("port_status", `OFS_PORT_STATUS, {27'h0, rx_ent == 8'h10, rx_ent != 8'h00,
                tx_ent == 8'h00, tx_ent < 8'h10, 1'b0});
            check("irq", {31'h0, irq}, {31'h0, |(raw & rnd[5:0])});
            check("dma_req", {30'h0, tx_dma_req, rx_dma_req}, {30'h0, rnd[1] & raw[0], rnd[0] & raw[4]});
            rd_chk("all_clear", `OFS_ALL_IRQ_CLEAR, {31'h0, |raw});
            sticky = 6'h00;
            rd_chk("raw_cleared", `OFS_IRQ_RAW, {26'h0, exp_raw()});
        end
        $display("test random_registers done");
        // Each clear register must drop its own source and leave the others set
        for (int k = 0; k < 3; k++)
        begin
            pulse(3'h7);
            rd_chk("clear_reg", clr_ofs[k], 32'h1);
            sticky[rbit[k]] = 1'b0;
            rd_chk("raw_after_clear", `OFS_IRQ_RAW, {26'h0, exp_raw()});
        end
        // Write-one clear drops every sticky source at once
        reg_write(`OFS_IRQ_WRITE_CLEAR, 32'h2e);
        sticky = 6'h00;
        rd_chk("raw_write_clear", `OFS_IRQ_RAW, {26'h0, exp_raw()});
        rd_chk("clear_idle", `OFS_TX_OVF_CLEAR, 32'h0);
        $display("test clear_on_read done");
        // Frames: none while disabled, count plus one once on, config locked
        reg_write(`OFS_TARGET_SELECT, 32'h1);
        reg_write(`OFS_FRAME_COUNT, 32'h1);
        reg_write(`OFS_CLOCK_DIVIDER, 32'h4);
        tx_ent <= 8'h03;
        repeat (40) @(posedge clock);
        check("idle_frames", {24'h0, frames}, 32'h0);
        reg_write(`OFS_GLOBAL_ENABLE, 32'h1);
        reg_write(`OFS_FRAME_COUNT, 32'h7);
        rd_chk("frame_locked", `OFS_FRAME_COUNT, 32'h1);
        for (int n = 0; n < 400 && !(frames == 8'h02 && select_n); n++) @(posedge clock);
        repeat (80) @(posedge clock);
        check("frames", {24'h0, frames}, 32'h2);
        check("sclk_edges", {24'h0, edges}, 32'h10);
        $display("test frames done");
        // Contention passes a two-stage synchroniser before it sticks
        contend <= 1'b1;
        underrun <= 1'b1;
        @(posedge clock);
        underrun <= 1'b0;
        repeat (5) @(posedge clock);
        contend <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        sticky[5] = 1'b1;
        rd_chk("status_errors", `OFS_PORT_STATUS, {25'h0, 2'b11, rx_ent == 8'h10,
            rx_ent != 8'h00, 3'b010});
        rd_chk("raw_contention", `OFS_IRQ_RAW, {26'h0, exp_raw()});
        rd_chk("contention_clear", `OFS_CONTENTION_CLEAR, 32'h1);
        sticky[5] = 1'b0;
        rd_chk("raw_after", `OFS_IRQ_RAW, {26'h0, exp_raw()});
        reg_write(`OFS_GLOBAL_ENABLE, 32'h0);
        $display("test contention done");
        give_verdict();
    end
endmodule
`default_nettype wire
